/* File: design/scf_ctrl.v */
// Filter clock generator, ready-edge A/D trigger and accumulation control with Avalon-MM registers
//
// Contract
// - Cutoff code 00..11 selects 9..12 Hz
// - Gain equals 56 plus four times field
// - Ready flag read-only, writes ignored
// - No auto conversion while ready low
// - Ready rising sets filter interrupt flag
// - Ready rise with auto enable starts conversion
// - Auto enable low, no automatic conversion
// - Prescaler divides system clock 8 to 1024
// - Divider divides prescaled clock by value+1
// - Unimplemented bits read as zero
// - Current source enable powers amp, reference
// - Four-bit reference voltage select, 16 steps
// - Battery detect bit enables resistor strings
// - Accumulate sixteen conversions into 16 bits
// - After sixteenth, clear busy, raise interrupt when enabled
// - Accumulate off gives 12-bit single conversion
// - Auto enable forces filter input channel
// - Newest conversion request takes priority
`timescale 1ns/1ps
`include "scf_ctrl_regs.vh"

module scf_ctrl (
  // Clock and reset
  input  wire                 sys_clk,
  input  wire                 sys_rst,
  // Avalon-MM slave
  input  wire [`ADDR_W-1:0]   avs_address,
  input  wire                 avs_read,
  input  wire                 avs_write,
  input  wire [31:0]          avs_writedata,
  output reg  [31:0]          avs_readdata,
  output reg                  avs_waitrequest,
  // Filter analog side
  input  wire                 filter_ready_in,
  output reg                  filter_clk,
  output reg  [1:0]           lowpass_cutoff_sel,
  output reg  [3:0]           cutoff_hz,
  output reg  [5:0]           filter_gain_sel,
  output reg  [8:0]           filter_gain,
  // Current source and battery detect
  output reg                  current_source_enable,
  output reg  [3:0]           current_ref_voltage_sel,
  output reg                  battery_detect_enable,
  // A/D converter and interrupt controller
  input  wire                 sw_conv_start,
  input  wire                 adc_int_enable,
  input  wire                 conv_done,
  input  wire [`SAMPLE_W-1:0] conv_sample,
  output reg                  conv_start,
  output reg                  force_filter_channel,
  output reg                  converter_busy,
  output reg  [`RES_W-1:0]    conv_result,
  output reg                  filter_irq_flag,
  output reg                  adc_irq
);

  reg  [7:0]  cutoff_gain_r;
  reg  [7:0]  clk_trig_r;
  reg  [7:0]  clk_div_r;
  reg  [7:0]  cur_src_r;
  reg         ready_s1_r;
  reg         ready_s2_r;
  reg         ready_d_r;
  reg  [9:0]  presc_cnt_r;
  reg  [7:0]  div_cnt_r;
  reg  [4:0]  acc_cnt_r;
  reg  [`RES_W-1:0] acc_sum_r;
  reg         access_done_r;
  reg  [31:0] rdata_nxt;

  wire [2:0] presc_sel  = clk_trig_r[`PRESC_MSB:`PRESC_LSB];
  wire       auto_en    = clk_trig_r[`AUTO_BIT];
  wire       acc_en     = cur_src_r[`ACC_BIT];
  // Prescaler counts half a prescaled period, so two toggles give the full ratio
  wire [9:0] presc_last = (`PRESC_HALF << presc_sel) - 10'h001;
  wire       presc_tick = (presc_cnt_r == presc_last);
  wire       ready_rise = ready_s2_r & ~ready_d_r;
  wire       auto_trig  = ready_rise & auto_en;
  wire       new_req    = auto_trig | sw_conv_start;
  wire       bus_req    = (avs_read | avs_write) & ~access_done_r;
  wire       acc_last   = (acc_cnt_r == `ACC_COUNT - 5'h01);

  // Ready comes from the analog filter, so it is synchronised first
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_s1_r <= 1'b0;
      ready_s2_r <= 1'b0;
      ready_d_r  <= 1'b0;
    end else begin
      ready_s1_r <= filter_ready_in;
      ready_s2_r <= ready_s1_r;
      ready_d_r  <= ready_s2_r;
    end
  end

  // One wait state; a write lands at the edge where waitrequest is seen low
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cutoff_gain_r   <= `REG_RST;
      clk_trig_r      <= `REG_RST;
      clk_div_r       <= `REG_RST;
      cur_src_r       <= `REG_RST;
      access_done_r   <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      access_done_r   <= bus_req;
      avs_waitrequest <= ~bus_req;
      avs_readdata    <= bus_req ? rdata_nxt : 32'h00000000;
      if (avs_write & access_done_r) begin
        if (avs_address == `OFS_CUTOFF_GAIN) begin
          cutoff_gain_r <= avs_writedata[7:0];
        end else if (avs_address == `OFS_CLK_TRIG) begin
          clk_trig_r <= avs_writedata[7:0] & `CLK_TRIG_WMASK;
        end else if (avs_address == `OFS_CLK_DIV) begin
          clk_div_r <= avs_writedata[7:0];
        end else if (avs_address == `OFS_CUR_SRC) begin
          cur_src_r <= avs_writedata[7:0] & `CUR_SRC_WMASK;
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_nxt = 32'h00000000;
    if (avs_address == `OFS_CUTOFF_GAIN) begin
      rdata_nxt[7:0] = cutoff_gain_r;
    end else if (avs_address == `OFS_CLK_TRIG) begin
      rdata_nxt[7:0] = clk_trig_r;
      rdata_nxt[`READY_BIT] = ready_s2_r;
    end else if (avs_address == `OFS_CLK_DIV) begin
      rdata_nxt[7:0] = clk_div_r;
    end else if (avs_address == `OFS_CUR_SRC) begin
      rdata_nxt[7:0] = cur_src_r;
    end
  end

  // Filter clock: half-period prescaler tick, then divide-by-(N+1) toggle,
  // so the output period is prescale times (N+1) system clocks.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_cnt_r <= 10'h000;
      div_cnt_r   <= 8'h00;
      filter_clk  <= 1'b0;
    end else begin
      presc_cnt_r <= presc_tick ? 10'h000 : presc_cnt_r + 10'h001;
      if (presc_tick) begin
        if (div_cnt_r >= clk_div_r) begin
          div_cnt_r  <= 8'h00;
          filter_clk <= ~filter_clk;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  // Decoded analog controls
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowpass_cutoff_sel      <= 2'h0;
      cutoff_hz               <= `CUTOFF_BASE_HZ;
      filter_gain_sel         <= 6'h00;
      filter_gain             <= `GAIN_BASE;
      current_source_enable   <= 1'b0;
      current_ref_voltage_sel <= 4'h0;
      battery_detect_enable   <= 1'b0;
      force_filter_channel    <= 1'b0;
    end else begin
      lowpass_cutoff_sel <= cutoff_gain_r[`CUTOFF_MSB:`CUTOFF_LSB];
      cutoff_hz <= `CUTOFF_BASE_HZ + {2'h0, cutoff_gain_r[`CUTOFF_MSB:`CUTOFF_LSB]};
      filter_gain_sel <= cutoff_gain_r[`GAIN_MSB:`GAIN_LSB];
      filter_gain <= `GAIN_BASE
                     + ({3'h0, cutoff_gain_r[`GAIN_MSB:`GAIN_LSB]} << `GAIN_STEP_SHIFT);
      current_source_enable   <= cur_src_r[`CS_EN_BIT];
      current_ref_voltage_sel <= cur_src_r[`VREF_MSB:`VREF_LSB];
      battery_detect_enable   <= cur_src_r[`BAT_EN_BIT];
      force_filter_channel    <= auto_en;
    end
  end

  // Filter interrupt flag: registered ready rise; the interrupt controller sees a pulse
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filter_irq_flag <= 1'b0;
    end else begin
      filter_irq_flag <= ready_rise;
    end
  end

  // Conversion sequencing. A new request restarts the sequence (newest wins).
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_start     <= 1'b0;
      converter_busy <= 1'b0;
      acc_cnt_r      <= 5'h00;
      acc_sum_r      <= {`RES_W{1'b0}};
      conv_result    <= {`RES_W{1'b0}};
      adc_irq        <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      adc_irq    <= 1'b0;
      if (new_req) begin
        conv_start     <= 1'b1;
        converter_busy <= 1'b1;
        acc_cnt_r      <= 5'h00;
        acc_sum_r      <= {`RES_W{1'b0}};
      end else if (converter_busy & conv_done) begin
        if (acc_en) begin
          acc_sum_r <= acc_sum_r + {4'h0, conv_sample};
          if (acc_last) begin
            conv_result    <= acc_sum_r + {4'h0, conv_sample};
            converter_busy <= 1'b0;
            adc_irq        <= adc_int_enable;
          end else begin
            acc_cnt_r  <= acc_cnt_r + 5'h01;
            conv_start <= 1'b1;
          end
        end else begin
          conv_result    <= {4'h0, conv_sample};
          converter_busy <= 1'b0;
          adc_irq        <= adc_int_enable;
        end
      end
    end
  end

endmodule // scf_ctrl

/* File: design/scf_ctrl_regs.vh */
// Register offsets, field positions and constants of the filter clock and A/D trigger block
`ifndef SCF_CTRL_REGS_VH
`define SCF_CTRL_REGS_VH
// Byte addresses on the Avalon-MM word bus (index times four)
`define ADDR_W             4
`define OFS_CUTOFF_GAIN    4'h0
`define OFS_CLK_TRIG       4'h4
`define OFS_CLK_DIV        4'h8
`define OFS_CUR_SRC        4'hC
// Field positions
`define CUTOFF_MSB         7
`define CUTOFF_LSB         6
`define GAIN_MSB           5
`define GAIN_LSB           0
`define READY_BIT          6
`define AUTO_BIT           5
`define PRESC_MSB          4
`define PRESC_LSB          2
`define CS_EN_BIT          7
`define BAT_EN_BIT         6
`define ACC_BIT            5
`define VREF_MSB           3
`define VREF_LSB           0
// Writable bit masks; other bits read zero except the ready flag
`define CLK_TRIG_WMASK     8'h3C
`define CUR_SRC_WMASK      8'hEF
`define REG_RST            8'h00
// Gain = base + step * field
`define GAIN_BASE          9'h038
`define GAIN_STEP_SHIFT    2
// Cutoff in Hz for code zero
`define CUTOFF_BASE_HZ     4'h9
// Half of the smallest prescaler (divide by 8); the output toggles twice per period
`define PRESC_HALF         10'h004
`define ACC_COUNT          5'h10
`define RES_W              16
`define SAMPLE_W           12
`define CONV_CYCLES        6'h20
`endif

/* File: tb/conv_partner.sv */
// Converter model: answers each start after a fixed delay, newest start wins
`timescale 1ns/1ps
module conv_partner #(
  parameter        LAT = 5,
  parameter [11:0] SMP = 12'hABC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Converter handshake
  input  wire        start,
  output reg         done,
  output wire [11:0] smp
);
  integer n;
  // Outside done the bus shows the inverse, never a stale match
  assign smp = done ? SMP : ~SMP;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      n <= 0;
      done <= 1'b0;
    end else begin
      done <= (n == 1);
      n <= start ? LAT : (n > 0 ? n - 1 : 0);
    end
  end
endmodule // conv_partner

/* File: tb/scf_ctrl_props.sv */
// Port-level checks of the filter clock and trigger block
`timescale 1ns/1ps
`include "scf_ctrl_regs.vh"
module scf_ctrl_props (
  // Clock, reset and bus
  input logic               sys_clk, sys_rst, avs_write, avs_read, avs_waitrequest,
  input logic [`ADDR_W-1:0] avs_address,
  input logic [31:0]        avs_writedata,
  // Filter and current source
  input logic               filter_ready_in, current_source_enable,
  input logic [1:0]         lowpass_cutoff_sel,
  input logic [3:0]         cutoff_hz,
  input logic [5:0]         filter_gain_sel,
  input logic [8:0]         filter_gain,
  // Converter side
  input logic               sw_conv_start, adc_int_enable, conv_done, conv_start,
  input logic               force_filter_channel, converter_busy, filter_irq_flag, adc_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire wr = avs_write && !avs_waitrequest;
  a_cutoff_map: assert property (cutoff_hz == 4'h9 + lowpass_cutoff_sel)
    else $error("cutoff frequency does not follow code");
  a_gain_map: assert property (filter_gain == 9'h038 + {filter_gain_sel, 2'b00})
    else $error("gain does not follow field");
  a_irq_single: assert property (filter_irq_flag |=> !filter_irq_flag)
    else $error("filter interrupt longer than one cycle");
  a_irq_cause: assert property (filter_irq_flag |-> $past(filter_ready_in, 2))
    else $error("filter interrupt without ready");
  a_auto_start: assert property (filter_irq_flag && force_filter_channel |-> ##[0:1] conv_start)
    else $error("ready rise did not start conversion");
  a_no_auto: assert property (conv_start && !force_filter_channel |->
    $past(sw_conv_start) || $past(conv_done))
    else $error("conversion started with auto off");
  a_auto_reg: assert property (wr && avs_address == `OFS_CLK_TRIG |->
    ##2 force_filter_channel == $past(avs_writedata[`AUTO_BIT], 2))
    else $error("channel force does not follow auto bit");
  a_cs_reg: assert property (wr && avs_address == `OFS_CUR_SRC |->
    ##2 current_source_enable == $past(avs_writedata[`CS_EN_BIT], 2))
    else $error("current source enable does not follow bit");
  a_done_irq: assert property (adc_irq |-> adc_int_enable ##[0:1] !converter_busy)
    else $error("converter interrupt with busy held or disabled");
  c_auto: cover property (filter_irq_flag && force_filter_channel);
  c_adc_irq: cover property (adc_irq);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // scf_ctrl_props
bind scf_ctrl scf_ctrl_props u_props (.*);

/* File: tb/scf_ctrl_tb.sv */
// Self-checking bench for the filter clock and trigger block
`timescale 1ns/1ps
`include "scf_ctrl_regs.vh"
module scf_ctrl_tb;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic        filter_ready_in = 1'b0, sw_conv_start = 1'b0, adc_int_enable = 1'b1;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, filter_clk, current_source_enable, battery_detect_enable;
  wire         conv_start, force_filter_channel, converter_busy, filter_irq_flag, adc_irq;
  wire         conv_done;
  wire  [1:0]  lowpass_cutoff_sel;
  wire  [3:0]  cutoff_hz, current_ref_voltage_sel;
  wire  [5:0]  filter_gain_sel;
  wire  [8:0]  filter_gain;
  wire  [11:0] conv_sample;
  wire  [15:0] conv_result;
  int          err_count = 0, tests_run = 0;
  logic [7:0]  q;
  always #20 sys_clk = ~sys_clk;
  scf_ctrl u_dut (.*);
  conv_partner u_adc (.clk(sys_clk), .rst(sys_rst), .start(conv_start), .done(conv_done),
    .smp(conv_sample));
  task report_and_stop;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Two idle cycles after each access keep strobes from being driven twice in a step
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (avs_waitrequest && k < 20);
    chk("waitrequest", 16'h0, avs_waitrequest);
    if (avs_waitrequest) report_and_stop;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task t_regs;
    for (int i = 0; i < 4; i++) begin
      bus(1, `OFS_CUTOFF_GAIN, {i[1:0], 6'h3F});
      chk("cutoff_hz", 16'h9 + i, cutoff_hz);
      chk("filter_gain", 16'h134, filter_gain);
    end
    bus(1, `OFS_CLK_TRIG, 8'hFF); bus(0, `OFS_CLK_TRIG, 8'h0);
    chk("clk_trig_rd", 16'h3C, q);
    bus(1, `OFS_CUR_SRC, 8'hDF); bus(0, `OFS_CUR_SRC, 8'h0);
    chk("cur_src_rd", 16'hCF, q);
    chk("cs_en", 16'h1, current_source_enable);
    chk("bat_en", 16'h1, battery_detect_enable);
    chk("vref_sel", 16'hF, current_ref_voltage_sel);
    bus(0, 4'h2, 8'h0);
    chk("unmapped_rd", 16'h0, q);
    bus(1, `OFS_CUR_SRC, 8'h00);
    chk("cs_off", 16'h0, current_source_enable);
  endtask
  task t_clk(input logic [7:0] ck, input logic [7:0] dv, input int ex);
    int n, r, t0, t1;
    logic p;
    bus(1, `OFS_CLK_TRIG, ck); bus(1, `OFS_CLK_DIV, dv);
    r = 0; t0 = 0; t1 = 0; p = filter_clk;
    for (n = 0; n < 8000 && r < 3; n++) begin
      @(posedge sys_clk);
      if (filter_clk && !p) begin r++; t0 = t1; t1 = n; end
      p = filter_clk;
    end
    chk("filter_clk_period", ex, t1 - t0);
    if (r < 3) report_and_stop;
  endtask
  // Accumulated run; in the software-start run a second start mid-run must restart the 16-sample count
  task t_acc(input logic sw);
    int n, s, d, rs;
    bus(1, `OFS_CUR_SRC, 8'h20); bus(1, `OFS_CLK_TRIG, sw ? 8'h00 : 8'h20);
    if (sw) sw_conv_start <= 1'b1; else filter_ready_in <= 1'b1;
    s = 0; d = 0; rs = 0;
    for (n = 0; n < 2000 && !adc_irq; n++) begin
      @(posedge sys_clk);
      sw_conv_start <= sw && !rs && d == 3 && conv_done;
      if (sw && !rs && d == 3 && conv_done) begin
        d = -1;
        rs = 1;
      end
      s += filter_irq_flag; d += conv_done;
    end
    chk("adc_irq", 16'h1, adc_irq);
    if (!adc_irq) report_and_stop;
    chk("done_count", 16'd16, d);
    @(posedge sys_clk);
    chk("acc_result", 16'hABC0, conv_result);
    chk("busy", 16'h0, converter_busy);
    if (!sw) chk("ready_irq", 16'h1, s);
  endtask
  task t_single;
    int n, c, s;
    filter_ready_in <= 1'b0;
    bus(1, `OFS_CUR_SRC, 8'h00); bus(1, `OFS_CLK_TRIG, 8'h00);
    filter_ready_in <= 1'b1;
    c = 0; s = 0;
    for (n = 0; n < 12; n++) begin @(posedge sys_clk); c += conv_start; s += filter_irq_flag; end
    chk("auto_off_starts", 16'h0, c);
    chk("auto_off_irq", 16'h1, s);
    sw_conv_start <= 1'b1;
    @(posedge sys_clk);
    sw_conv_start <= 1'b0;
    for (n = 0; n < 50 && !conv_done; n++) @(posedge sys_clk);
    chk("conv_done", 16'h1, conv_done);
    if (!conv_done) report_and_stop;
    repeat (2) @(posedge sys_clk);
    chk("single_result", 16'h0ABC, conv_result);
    chk("single_busy", 16'h0, converter_busy);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk("gain_rst", 16'h38, filter_gain);
    t_regs;
    t_clk(8'h04, 8'h02, 48);
    t_clk(8'h1C, 8'h00, 1024);
    t_acc(1'b0);
    t_single;
    t_acc(1'b1);
    report_and_stop;
  end
endmodule // scf_ctrl_tb
